// ===== rtl/dtom_regs.svh
// Constants for the dual-channel torque-off monitor
`ifndef DTOM_REGS_SVH
`define DTOM_REGS_SVH

// ==========================================================
// Clock and timing limits
`define DTOM_CLK_KHZ 100000
`define DTOM_BREAK_MS 1
`define DTOM_RESPONSE_TYP_MS 2
`define DTOM_RESPONSE_MAX_MS 30
`define DTOM_MISMATCH_MS 200
`define DTOM_REACTION_MS 10
`define DTOM_FAULT_IND_MS 500
`define DTOM_WARN_IND_MS 1000

// ==========================================================
// Counter width and reset values
`define DTOM_TMR_W 25
`define DTOM_CNT_ZERO 25'h0000000
`define DTOM_CNT_ONE 25'h0000001
`define DTOM_CHAN_RST 1'h0
`define DTOM_FLAG_RST 1'h0
`define DTOM_FLAG_SET 1'h1

`endif

// ===== rtl/dtom_pkg.sv
// Types for the dual-channel torque-off monitor
package dtom_pkg;

  // ==========================================================
  // Drive states, Gray coded around the usual cycle
  typedef enum logic [1:0] {
    DTOM_ST_READY = 2'h0,
    DTOM_ST_RUN = 2'h1,
    DTOM_ST_TORQUE_OFF = 2'h3,
    DTOM_ST_WAIT_RESET = 2'h2
  } dtom_state_t;

  // ==========================================================
  // Indication selection
  typedef enum logic [1:0] {
    DTOM_IND_NONE = 2'h0,
    DTOM_IND_EVENT = 2'h1,
    DTOM_IND_WARNING = 2'h2,
    DTOM_IND_FAULT = 2'h3
  } dtom_ind_sel_t;

  // ==========================================================
  // Per-module state records
  typedef struct packed {
    logic stage1;
    logic stage2;
  } dtom_sync_st_t;

  typedef struct packed {
    logic [24:0] cnt;
    logic expired;
  } dtom_tmr_st_t;

  typedef struct packed {
    dtom_state_t state;
    logic gateEnable;
    logic torqueOff;
    logic restartBlocked;
    logic startRefused;
    logic hwFault;
    logic chan1Loss;
    logic chan2Loss;
    logic eventInd;
    logic warningInd;
    logic faultInd;
    logic diagAvailable;
  } dtom_top_st_t;

endpackage

// ===== rtl/dtom_chan_sync.sv
// Two-stage synchroniser for one torque-removal input channel
`timescale 1ns/10ps
`default_nettype none
`include "dtom_regs.svh"

module dtom_chan_sync
  import dtom_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic chanIn,
  output logic chanSync
);

  // ==========================================================
  // State
  dtom_sync_st_t st_r;
  dtom_sync_st_t st_nxt;

  // Stage 1 feeds only stage 2
  always_comb begin
    st_nxt = st_r;
    st_nxt.stage1 = chanIn;
    st_nxt.stage2 = st_r.stage1;
  end

  // Reset reads as de-energized, the safe side
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= {`DTOM_CHAN_RST, `DTOM_CHAN_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chanSync = st_r.stage2;

endmodule
`default_nettype wire

// ===== rtl/dtom_ms_timer.sv
// Cycle timer that flags when a condition has lasted more than LIMIT cycles
`timescale 1ns/10ps
`default_nettype none
`include "dtom_regs.svh"

module dtom_ms_timer
  import dtom_pkg::*;
#(
  parameter int unsigned LIMIT = 1
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  output logic expired
);

  // ==========================================================
  // State
  localparam logic [`DTOM_TMR_W-1:0] LIMIT_W = LIMIT[`DTOM_TMR_W-1:0];

  dtom_tmr_st_t st_r;
  dtom_tmr_st_t st_nxt;

  // Restarts from zero whenever the condition drops
  always_comb begin
    st_nxt = st_r;
    if (!run) begin
      st_nxt.cnt = `DTOM_CNT_ZERO;
      st_nxt.expired = `DTOM_FLAG_RST;
    end else if (st_r.cnt == LIMIT_W) begin
      st_nxt.expired = `DTOM_FLAG_SET;
    end else begin
      st_nxt.cnt = st_r.cnt + `DTOM_CNT_ONE;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= {`DTOM_CNT_ZERO, `DTOM_FLAG_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;

endmodule
`default_nettype wire

// ===== rtl/dtom_monitor.sv
// Dual-channel torque-off monitor: gate control, restart lock, cross-check, indications
//
// Contract
// [RL1] Both inputs de-energized removes power switch gate drive.
// [RL2] Torque removal raises the indication picked by the selection input.
// [RL3] Start requests refused while either input contact stays open.
// [RL4] After inputs close, a fault reset is needed before restart.
// [RL5] Torque removal overrides every other gate enable path.
// [RL6] Channels compared continuously; disagreement trips a hardware failure fault.
// [RL7] Single-channel use is treated exactly like a channel mismatch.
// [RL8] An input break of one millisecond is caught as a request.
// [RL9] Gate drive removed within 2 ms typical, 30 ms maximum.
// [RL10] Mismatch faults only after channels differ for over 200 ms.
// [RL11] Fault reaction completes within 10 ms of mismatch detection.
// [RL12] Fault indication issued under 500 ms after its cause.
// [RL13] Warning indication issued under 1000 ms after its cause.
// [RL14] No mismatch fault during power outage or auxiliary-module-only supply.
// [RL15] Controller should stop the drive before removing torque, if coasting matters.
// [RL16] First and second channel losses raise separate fault indications.
// [RL17] Inputs synchronised; timers count clock cycles scaled from milliseconds.
`timescale 1ns/10ps
`default_nettype none
`include "dtom_regs.svh"

module dtom_monitor
  import dtom_pkg::*;
#(
  parameter int unsigned MISMATCH_CYCLES = `DTOM_MISMATCH_MS * `DTOM_CLK_KHZ
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic torqueIn1,
  input wire logic torqueIn2,
  input wire logic startReq,
  input wire logic stopReq,
  input wire logic faultResetReq,
  input wire logic driveGateReq,
  input wire logic powerOutage,
  input wire logic auxPowerExtensionModule,
  input wire logic [1:0] indicationSel,
  output logic gateEnable,
  output logic torqueRemovalActive,
  output logic restartBlocked,
  output logic startRefused,
  output logic hwFailureFault,
  output logic chan1LossFault,
  output logic chan2LossFault,
  output logic eventIndication,
  output logic warningIndication,
  output logic faultIndication,
  output logic diagAvailable
);

  // ==========================================================
  // Timing figures, derived from the clock rate
  localparam int unsigned BREAK_CYCLES = `DTOM_BREAK_MS * `DTOM_CLK_KHZ;
  localparam int unsigned RESPONSE_MAX_CYCLES = `DTOM_RESPONSE_MAX_MS * `DTOM_CLK_KHZ;
  localparam int unsigned REACTION_CYCLES = `DTOM_REACTION_MS * `DTOM_CLK_KHZ;
  localparam int unsigned FAULT_IND_CYCLES = `DTOM_FAULT_IND_MS * `DTOM_CLK_KHZ;
  localparam int unsigned WARN_IND_CYCLES = `DTOM_WARN_IND_MS * `DTOM_CLK_KHZ;
  // Path latency is three cycles (two sync stages and one output flop), far below
  // the break, response, reaction and indication limits above.

  // ==========================================================
  // Input synchronisers, one per channel
  logic [1:0] chanRaw;
  logic [1:0] chanSync;

  assign chanRaw = {torqueIn2, torqueIn1};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      dtom_chan_sync u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .chanIn(chanRaw[gi]),
        .chanSync(chanSync[gi])
      ); // see [RL17]
    end
  endgenerate

  // ==========================================================
  // Channel status
  logic chan1On;
  logic chan2On;
  logic bothOn;
  logic anyOff;
  logic mismatch;
  logic diagOk;
  logic mismatchExpired;

  assign chan1On = chanSync[0];
  assign chan2On = chanSync[1];
  assign bothOn = chan1On && chan2On;
  // Any open channel removes gate drive: one dead channel must never leave torque on
  assign anyOff = !chan1On || !chan2On; // see [RL1] see [RL8]
  assign mismatch = chan1On != chan2On; // see [RL6] see [RL7]
  assign diagOk = !powerOutage && !auxPowerExtensionModule; // see [RL14]

  // ==========================================================
  // Mismatch duration timer
  dtom_ms_timer #(
    .LIMIT(MISMATCH_CYCLES)
  ) u_mismatch_tmr (
    .core_clk(core_clk),
    .reset(reset),
    .run(mismatch && diagOk),
    .expired(mismatchExpired)
  ); // see [RL10] see [RL17]

  // ==========================================================
  // State
  dtom_top_st_t st_r;
  dtom_top_st_t st_nxt;

  logic faultActive;
  logic indicationDue;

  assign faultActive = st_r.hwFault || st_r.chan1Loss || st_r.chan2Loss;

  always_comb begin
    st_nxt = st_r;
    indicationDue = `DTOM_FLAG_RST;
    st_nxt.startRefused = `DTOM_FLAG_RST;
    st_nxt.eventInd = `DTOM_FLAG_RST;
    st_nxt.diagAvailable = diagOk;

    // ==========================================================
    // Cross-check trip; a new trip wins over a reset in the same cycle
    if (mismatchExpired) begin
      st_nxt.hwFault = `DTOM_FLAG_SET; // see [RL6] see [RL7] see [RL11]
      if (!chan1On) begin
        st_nxt.chan1Loss = `DTOM_FLAG_SET; // see [RL16]
      end
      if (!chan2On) begin
        st_nxt.chan2Loss = `DTOM_FLAG_SET; // see [RL16]
      end
    end

    // ==========================================================
    // Drive sequence
    case (st_r.state)
      DTOM_ST_READY: begin
        if (anyOff) begin
          st_nxt.state = DTOM_ST_TORQUE_OFF; // see [RL1]
          indicationDue = `DTOM_FLAG_SET;
          if (startReq) begin
            st_nxt.startRefused = `DTOM_FLAG_SET; // see [RL3]
          end
        end else if (startReq) begin
          if (faultActive || mismatchExpired) begin
            st_nxt.startRefused = `DTOM_FLAG_SET; // see [RL4]
          end else begin
            st_nxt.state = DTOM_ST_RUN;
          end
        end
      end
      DTOM_ST_RUN: begin
        if (anyOff) begin
          // Motor coasts; a controlled stop must come from the controller first
          st_nxt.state = DTOM_ST_TORQUE_OFF; // see [RL1] see [RL15]
          indicationDue = `DTOM_FLAG_SET;
        end else if (stopReq || mismatchExpired) begin
          st_nxt.state = DTOM_ST_READY;
        end
      end
      DTOM_ST_TORQUE_OFF: begin
        if (startReq) begin
          st_nxt.startRefused = `DTOM_FLAG_SET; // see [RL3]
        end
        if (bothOn) begin
          st_nxt.state = DTOM_ST_WAIT_RESET; // see [RL4]
        end
      end
      DTOM_ST_WAIT_RESET: begin
        // A start that lands with the fault reset is refused too; the reset must come first
        if (startReq) begin
          st_nxt.startRefused = `DTOM_FLAG_SET; // see [RL3] see [RL4]
        end
        if (anyOff) begin
          st_nxt.state = DTOM_ST_TORQUE_OFF; // see [RL1]
          indicationDue = `DTOM_FLAG_SET; // see [RL2]
        end else if (faultResetReq && !mismatchExpired) begin
          st_nxt.state = DTOM_ST_READY; // see [RL4]
          st_nxt.hwFault = `DTOM_FLAG_RST;
          st_nxt.chan1Loss = `DTOM_FLAG_RST;
          st_nxt.chan2Loss = `DTOM_FLAG_RST;
        end
      end
      default: begin
        st_nxt.state = DTOM_ST_TORQUE_OFF;
      end
    endcase

    // ==========================================================
    // Fault reset also clears a latched trip in any state but torque-off, once both inputs are on
    if (faultResetReq && bothOn && !mismatchExpired && st_r.state != DTOM_ST_TORQUE_OFF) begin
      st_nxt.hwFault = `DTOM_FLAG_RST;
      st_nxt.chan1Loss = `DTOM_FLAG_RST;
      st_nxt.chan2Loss = `DTOM_FLAG_RST;
    end

    // ==========================================================
    // Gate drive: only the run state with both channels on and no trip
    st_nxt.gateEnable = (st_nxt.state == DTOM_ST_RUN) && driveGateReq && bothOn
                        && !st_nxt.hwFault; // see [RL5] see [RL9] see [RL11]
    st_nxt.torqueOff = anyOff; // see [RL1]
    st_nxt.restartBlocked = anyOff || (st_nxt.state == DTOM_ST_WAIT_RESET)
                            || st_nxt.hwFault; // see [RL3] see [RL4]

    // ==========================================================
    // Indications per selection; levels hold while torque removal stays active
    if (indicationDue && indicationSel == DTOM_IND_EVENT) begin
      st_nxt.eventInd = `DTOM_FLAG_SET; // see [RL2]
    end
    st_nxt.warningInd = anyOff && (indicationSel == DTOM_IND_WARNING); // see [RL2] see [RL13]
    st_nxt.faultInd = (anyOff && (indicationSel == DTOM_IND_FAULT))
                      || st_nxt.hwFault; // see [RL2] see [RL12]
  end

  // ==========================================================
  // Registers; reset comes up with gates off and restart blocked
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r.state <= DTOM_ST_TORQUE_OFF;
      st_r.gateEnable <= `DTOM_FLAG_RST;
      st_r.torqueOff <= `DTOM_FLAG_SET;
      st_r.restartBlocked <= `DTOM_FLAG_SET;
      st_r.startRefused <= `DTOM_FLAG_RST;
      st_r.hwFault <= `DTOM_FLAG_RST;
      st_r.chan1Loss <= `DTOM_FLAG_RST;
      st_r.chan2Loss <= `DTOM_FLAG_RST;
      st_r.eventInd <= `DTOM_FLAG_RST;
      st_r.warningInd <= `DTOM_FLAG_RST;
      st_r.faultInd <= `DTOM_FLAG_RST;
      st_r.diagAvailable <= `DTOM_FLAG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign gateEnable = st_r.gateEnable;
  assign torqueRemovalActive = st_r.torqueOff;
  assign restartBlocked = st_r.restartBlocked;
  assign startRefused = st_r.startRefused;
  assign hwFailureFault = st_r.hwFault;
  assign chan1LossFault = st_r.chan1Loss;
  assign chan2LossFault = st_r.chan2Loss;
  assign eventIndication = st_r.eventInd;
  assign warningIndication = st_r.warningInd;
  assign faultIndication = st_r.faultInd;
  assign diagAvailable = st_r.diagAvailable;

endmodule
`default_nettype wire

// ===== sim/dtom_monitor_sva.sv
// Assertions for the torque-off monitor
`timescale 1ns/10ps
`default_nettype none
module dtom_monitor_sva #(
  parameter int unsigned MISMATCH_CYCLES = 20
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic torqueIn1,
  input wire logic torqueIn2,
  input wire logic startReq,
  input wire logic faultResetReq,
  input wire logic powerOutage,
  input wire logic auxPowerExtensionModule,
  input wire logic [1:0] indicationSel,
  input wire logic gateEnable,
  input wire logic torqueRemovalActive,
  input wire logic restartBlocked,
  input wire logic startRefused,
  input wire logic hwFailureFault,
  input wire logic chan1LossFault,
  input wire logic chan2LossFault,
  input wire logic eventIndication,
  input wire logic warningIndication,
  input wire logic faultIndication,
  input wire logic diagAvailable
);
  // =====
  // Pin delay matching the input synchroniser, then a disagreement count
  logic [1:0] dA_r;
  logic [1:0] dB_r;
  int unsigned dCnt_r;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dA_r <= 2'h0;
      dB_r <= 2'h0;
      dCnt_r <= 0;
    end else begin
      dA_r <= {dA_r[0], torqueIn1};
      dB_r <= {dB_r[0], torqueIn2};
      // Counts only while diagnostics run, as the trip timer does
      dCnt_r <= ((dA_r[1] != dB_r[1]) && !powerOutage && !auxPowerExtensionModule) ? dCnt_r + 1 : 0;
    end
  end
  // =====
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  gate_vs_removal_a: assert property (torqueRemovalActive |-> !gateEnable)
    else $error("gate enabled during torque removal");
  open_cuts_gate_a: assert property ((!torqueIn1 || !torqueIn2) |-> ##3 !gateEnable)
    else $error("gate not removed after input break");
  removal_blocks_a: assert property (torqueRemovalActive |-> restartBlocked)
    else $error("restart not blocked while open");
  refuse_start_a: assert property (startReq && restartBlocked |=> startRefused)
    else $error("blocked start not refused");
  refuse_cause_a: assert property (startRefused |-> $past(startReq))
    else $error("refusal without start request");
  reset_needed_a: assert property ($fell(restartBlocked) |-> $past(faultResetReq))
    else $error("restart unblocked without fault reset");
  mismatch_min_a: assert property ($rose(hwFailureFault) |-> dCnt_r > MISMATCH_CYCLES)
    else $error("mismatch trip too early");
  mismatch_max_a: assert property (dCnt_r == MISMATCH_CYCLES + 3 && diagAvailable |-> ##[0:3] hwFailureFault)
    else $error("mismatch trip too late");
  loss_names_a: assert property ($rose(hwFailureFault) |-> chan1LossFault != chan2LossFault)
    else $error("channel loss faults do not name one channel");
  fault_diag_a: assert property ($rose(hwFailureFault) |-> $past(diagAvailable))
    else $error("trip without diagnostics");
  warn_sel_a: assert property (warningIndication |-> $past(indicationSel) == 2'h2)
    else $error("warning with wrong selection");
  fault_sel_a: assert property (faultIndication |-> hwFailureFault || $past(indicationSel) == 2'h3)
    else $error("fault indication without cause");
  event_pulse_a: assert property (eventIndication |=> !eventIndication)
    else $error("event indication longer than one cycle");
  cover property ($rose(hwFailureFault));
  cover property (startRefused);
  cover property ($rose(gateEnable));
  cover property (warningIndication);
endmodule
bind dtom_monitor dtom_monitor_sva #(.MISMATCH_CYCLES(MISMATCH_CYCLES)) chk_u (.*);
`default_nettype wire

// ===== sim/dtom_contact_model.sv
// Switch or relay contacts feeding the two torque-removal channels
`timescale 1ns/10ps
`default_nettype none
module dtom_contact_model (
  input wire logic core_clk,
  input wire logic open1,
  input wire logic open2,
  input wire logic slow,
  output var logic torqueIn1,
  output var logic torqueIn2
);
  // =====
  // Contacts move just after an edge; slow adds one cycle of travel
  logic p1 = 1'b1;
  logic p2 = 1'b1;
  initial begin
    torqueIn1 = 1'b1;
    torqueIn2 = 1'b1;
  end
  always @(posedge core_clk) begin
    p1 <= !open1;
    p2 <= !open2;
    torqueIn1 <= slow ? p1 : !open1;
    torqueIn2 <= slow ? p2 : !open2;
  end
endmodule
`default_nettype wire

// ===== sim/dual_channel_torque_off_monitor_test.sv
// Self-checking bench for the torque-off monitor
`timescale 1ns/10ps
`default_nettype none
module dual_channel_torque_off_monitor_test;
  // =====
  // Stimulus and wiring; short mismatch time keeps the run brief
  localparam int MC = 20;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic open1 = 1'b0, open2 = 1'b0, slow = 1'b0, torqueIn1, torqueIn2;
  logic startReq = 1'b0, stopReq = 1'b0, faultResetReq = 1'b0, driveGateReq = 1'b1;
  logic powerOutage = 1'b0, auxPowerExtensionModule = 1'b0;
  logic [1:0] indicationSel = 2'h0;
  logic gateEnable, torqueRemovalActive, restartBlocked, startRefused, hwFailureFault;
  logic chan1LossFault, chan2LossFault, eventIndication, warningIndication, faultIndication, diagAvailable;
  int n_mismatch = 0, check_count = 0, seenEv, n;
  logic [31:0] lfsrVal = 32'h24ED36F5;
  always #5 core_clk = ~core_clk;
  dtom_monitor #(.MISMATCH_CYCLES(MC)) dut_u (.*);
  dtom_contact_model pm_u (.*);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // =====
  // Shared tasks
  task automatic chk(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(negedge core_clk);
  endtask
  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Refusal pulse may land one or two edges after the request
  task automatic try_start(input logic exp);
    logic seen;
    seen = 1'b0;
    startReq = 1'b1;
    tick(1);
    startReq = 1'b0;
    repeat (2) begin
      seen = seen | startRefused;
      tick(1);
    end
    chk(seen, exp, "start refusal");
  endtask
  task automatic restart;
    faultResetReq = 1'b1;
    tick(1);
    faultResetReq = 1'b0;
    try_start(1'b0);
    chk(gateEnable, 1'b1, "gate after restart");
    chk(restartBlocked, 1'b0, "unblocked after restart");
  endtask
  // =====
  // Scenarios
  initial begin
    tick(7);
    chk(gateEnable, 1'b0, "gate in reset");
    chk(restartBlocked, 1'b1, "blocked in reset");
    tick(1);
    reset = 1'b0;
    tick(6);
    try_start(1'b1);
    restart;
    for (int s = 0; s < 4; s++) begin
      indicationSel = s[1:0];
      slow = s[0];
      seenEv = 0;
      if (s == 3) begin
        stopReq = 1'b1;
        tick(1);
        stopReq = 1'b0;
      end
      open1 = 1'b1;
      open2 = 1'b1;
      repeat (s == 0 ? 1 : 8) begin
        lfsrVal = lfsr_next(lfsrVal);
        driveGateReq = lfsrVal[0];
        startReq = lfsrVal[1];
        tick(1);
        seenEv += eventIndication;
      end
      startReq = 1'b0;
      driveGateReq = 1'b1;
      if (s > 0) begin
        chk(gateEnable, 1'b0, "gate while open");
        chk(torqueRemovalActive, 1'b1, "removal active while open");
        try_start(1'b1);
      end
      chk(warningIndication, s == 2, "warning level");
      chk(faultIndication, s == 3, "fault level");
      chk(seenEv == 1, s == 1, "event pulse");
      open1 = 1'b0;
      open2 = 1'b0;
      tick(4);
      chk(gateEnable, 1'b0, "gate after break");
      tick(4);
      restart;
    end
    for (int c = 0; c < 2; c++) begin
      open1 = (c == 0);
      open2 = (c == 1);
      n = 0;
      while (hwFailureFault !== 1'b1 && n < 4 * MC) begin
        tick(1);
        n++;
      end
      chk(n > MC && n < MC + 8, 1'b1, "mismatch trip time");
      if (n >= 4 * MC) report_and_stop;
      chk(chan1LossFault, c == 0, "channel one loss");
      chk(chan2LossFault, c == 1, "channel two loss");
      chk(faultIndication, 1'b1, "trip indication");
      chk(gateEnable, 1'b0, "gate after one channel");
      open1 = 1'b0;
      open2 = 1'b0;
      tick(6);
      restart;
      chk(hwFailureFault, 1'b0, "fault cleared");
    end
    for (int d = 0; d < 2; d++) begin
      powerOutage = (d == 0);
      auxPowerExtensionModule = (d == 1);
      tick(2);
      chk(diagAvailable, 1'b0, "diagnostics off");
      open1 = 1'b1;
      tick(3 * MC);
      chk(hwFailureFault, 1'b0, "no trip without diagnostics");
      open1 = 1'b0;
      powerOutage = 1'b0;
      auxPowerExtensionModule = 1'b0;
      tick(6);
      restart;
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
